// ==== hw/ssm_monitor.sv ====
/*
  Servo sequence monitor: speed detection outputs with hysteresis,
  main power loss handling and over-travel stop sequence.
  Assumes one 20 MHz clock, settings held stable by the host,
  and discrete pins that are asynchronous to the clock.
*/
`include "ssm_cfg.svh"
`default_nettype none
module ssm_monitor #(
  parameter int SPEED_W = 16,
  parameter int TORQUE_W = 16,
  parameter int CYC_PER_MS = `SSM_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic signed [SPEED_W-1:0] motor_speed,
  input wire logic signed [SPEED_W-1:0] speed_cmd,
  input wire logic signed [TORQUE_W-1:0] torque_cmd_in,
  input wire logic [`SSM_THR_W-1:0] zero_speed_threshold,
  input wire logic [`SSM_THR_W-1:0] at_speed_threshold,
  input wire logic undervoltage_trip_select,
  input wire ssm_pkg::ssm_ot_sel_t overtravel_sequence_select,
  input wire logic [`SSM_DET_W-1:0] power_off_detect_time,
  input wire logic [8:0] estop_torque_setting,
  input wire logic [8:0] normal_torque_limit,
  input wire logic servo_on_pin,
  input wire logic alarm_clear_pin,
  input wire logic main_power_ok_pin,
  input wire logic bus_voltage_low_pin,
  input wire logic cw_travel_inhibit,
  input wire logic ccw_travel_inhibit,
  output logic zero_speed_out,
  output logic alt_zero_speed_pin,
  output logic speed_match_out,
  output logic at_speed_out,
  output logic main_undervoltage_error,
  output logic servo_active,
  output logic dynamic_brake,
  output logic deviation_hold,
  output logic signed [TORQUE_W-1:0] torque_cmd_out,
  output logic [8:0] torque_limit_out
);
  import ssm_pkg::*;
  if (SPEED_W < 16 || SPEED_W > 31 || CYC_PER_MS < 1) begin : g_bad
    $error("ssm_monitor: unsupported parameter values");
  end
  localparam int MAG_W = SPEED_W + 1;
  // Shared by speed and speed-error paths
  function automatic logic [MAG_W-1:0] mag(input logic signed [MAG_W-1:0] v);
    mag = v[MAG_W-1] ? MAG_W'(-v) : MAG_W'(v);
  endfunction : mag
  logic servo_on_s;
  logic alarm_clear_s;
  logic power_ok_s;
  logic bus_low_s;
  logic cw_s;
  logic ccw_s;
  ssm_sync u_son (.clk(clk), .rst(rst), .pin(servo_on_pin),
    .level(servo_on_s));
  ssm_sync u_aclr (.clk(clk), .rst(rst), .pin(alarm_clear_pin),
    .level(alarm_clear_s));
  ssm_sync u_pok (.clk(clk), .rst(rst), .pin(main_power_ok_pin),
    .level(power_ok_s));
  ssm_sync u_blow (.clk(clk), .rst(rst), .pin(bus_voltage_low_pin),
    .level(bus_low_s));
  ssm_sync u_cw (.clk(clk), .rst(rst), .pin(cw_travel_inhibit),
    .level(cw_s));
  ssm_sync u_ccw (.clk(clk), .rst(rst), .pin(ccw_travel_inhibit),
    .level(ccw_s));
  logic [MAG_W-1:0] spd_mag;
  logic [MAG_W-1:0] err_mag;
  logic [MAG_W-1:0] zthr;
  logic [MAG_W-1:0] athr;
  assign spd_mag = mag(MAG_W'(motor_speed));
  assign err_mag = mag(MAG_W'(speed_cmd) - MAG_W'(motor_speed));
  assign zthr = MAG_W'(zero_speed_threshold);
  assign athr = MAG_W'(at_speed_threshold);
  // Set below threshold, release only at threshold plus band
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_speed_out <= 1'h1;
    end else if (spd_mag < zthr) begin
      zero_speed_out <= 1'h1;
    end else if (spd_mag >= zthr + MAG_W'(`SSM_HYST_RPM)) begin
      zero_speed_out <= 1'h0;
    end
  end
  assign alt_zero_speed_pin = zero_speed_out;
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_match_out <= 1'h1;
    end else if (err_mag < zthr) begin
      speed_match_out <= 1'h1;
    end else if (err_mag >= zthr + MAG_W'(`SSM_HYST_RPM)) begin
      speed_match_out <= 1'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      at_speed_out <= 1'h0;
    end else if (spd_mag > athr) begin
      at_speed_out <= 1'h1;
    end else if (spd_mag + MAG_W'(`SSM_HYST_RPM) <= athr) begin
      at_speed_out <= 1'h0;
    end
  end
  // Millisecond enable; a parameter so simulation can shorten it
  logic [31:0] ms_div;
  logic ms_tick;
  always_ff @(posedge clk) begin
    if (rst || ms_div == 32'(CYC_PER_MS - 1)) begin
      ms_div <= 32'h0;
    end else begin
      ms_div <= ms_div + 32'h1;
    end
  end
  assign ms_tick = (ms_div == 32'(CYC_PER_MS - 1));
  logic [`SSM_DET_W-1:0] off_ms;
  logic det_ignore;
  logic power_lost;
  always_ff @(posedge clk) begin
    if (rst || power_ok_s) begin
      off_ms <= '0;
    end else if (ms_tick && off_ms != '1) begin
      off_ms <= off_ms + `SSM_DET_W'(1);
    end
  end
  // At the ignore setting no shutoff is declared; only the bus level trips
  assign det_ignore = (power_off_detect_time == `SSM_DET_IGNORE);
  assign power_lost = !power_ok_s && !det_ignore &&
                      off_ms >= power_off_detect_time;
  ssm_state_t state;
  ssm_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      SSM_OFF: begin
        if (servo_on_s && power_ok_s) begin
          next_state = SSM_ON;
        end
      end
      SSM_ON: begin
        if (power_lost && undervoltage_trip_select) begin
          next_state = SSM_TRIP;
        end else if (power_lost) begin
          next_state = SSM_PWR_WAIT;
        end else if (!servo_on_s) begin
          next_state = SSM_OFF;
        end
      end
      SSM_PWR_WAIT: begin
        if (!servo_on_s) begin
          next_state = SSM_OFF;
        end else if (power_ok_s) begin
          next_state = SSM_ON;
        end
      end
      SSM_TRIP: begin
        // Set wins: a still-low bus keeps the error against a clear
        if (alarm_clear_s && power_ok_s && !bus_low_s) begin
          next_state = SSM_OFF;
        end
      end
      default: next_state = SSM_OFF;
    endcase
    // Low bus before a detected shutoff trips from every state
    if (bus_low_s && !power_lost) begin
      next_state = SSM_TRIP;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SSM_OFF;
    end else begin
      state <= next_state;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      main_undervoltage_error <= 1'h0;
      servo_active <= 1'h0;
    end else begin
      main_undervoltage_error <= (next_state == SSM_TRIP);
      servo_active <= (next_state == SSM_ON);
    end
  end
  // Selection captured once after power-up, later writes wait for one
  ssm_ot_sel_t ot_sel;
  logic ot_loaded;
  always_ff @(posedge clk) begin
    if (rst) begin
      ot_sel <= ssm_ot_sel_t'(`SSM_OT_SEL_RST);
      ot_loaded <= 1'h0;
    end else if (!ot_loaded) begin
      ot_sel <= overtravel_sequence_select;
      ot_loaded <= 1'h1;
    end
  end
  logic ot_active;
  logic stalled;
  logic toward_cw;
  logic toward_ccw;
  assign ot_active = (cw_s || ccw_s) && state == SSM_ON;
  assign stalled = zero_speed_out;
  // Positive torque drives clockwise
  assign toward_cw = !torque_cmd_in[TORQUE_W-1] && torque_cmd_in != '0;
  assign toward_ccw = torque_cmd_in[TORQUE_W-1];
  always_ff @(posedge clk) begin
    if (rst) begin
      torque_cmd_out <= '0;
      torque_limit_out <= 9'h000;
      dynamic_brake <= 1'h0;
      deviation_hold <= 1'h0;
    end else begin
      // Servo off passes no torque; ot_active implies servo on
      torque_cmd_out <= (state == SSM_ON) ? torque_cmd_in : '0;
      torque_limit_out <= normal_torque_limit;
      dynamic_brake <= 1'h0;
      deviation_hold <= ot_active;
      if (ot_active && stalled) begin
        // Zero torque only toward the inhibited side
        if ((cw_s && toward_cw) || (ccw_s && toward_ccw)) begin
          torque_cmd_out <= '0;
        end
      end else if (ot_active && ot_sel == SSM_OT_ESTOP) begin
        torque_limit_out <= estop_torque_setting;
      end else if (ot_active) begin
        torque_cmd_out <= '0;
        dynamic_brake <= (ot_sel != SSM_OT_TQ0);
      end
    end
  end
  zero_set_a: assert property (@(posedge clk) disable iff (rst)
    spd_mag < zthr |=> zero_speed_out)
    else $error("zero-speed not set below threshold");
  zero_band_a: assert property (@(posedge clk) disable iff (rst)
    zero_speed_out && spd_mag < zthr + MAG_W'(10) |=> zero_speed_out)
    else $error("zero-speed released inside band");
  zero_clr_a: assert property (@(posedge clk) disable iff (rst)
    spd_mag >= zthr + MAG_W'(10) |=> !zero_speed_out)
    else $error("zero-speed held above band");
  match_set_a: assert property (@(posedge clk) disable iff (rst)
    err_mag < zthr |=> speed_match_out)
    else $error("speed-match not set");
  at_set_a: assert property (@(posedge clk) disable iff (rst)
    spd_mag > athr |=> at_speed_out)
    else $error("at-speed not set");
  at_clr_a: assert property (@(posedge clk) disable iff (rst)
    spd_mag + MAG_W'(10) <= athr |=> !at_speed_out)
    else $error("at-speed held below band");
  power_trip_a: assert property (@(posedge clk) disable iff (rst)
    state == SSM_ON && power_lost && undervoltage_trip_select
    |=> main_undervoltage_error && state == SSM_TRIP)
    else $error("no trip on power loss");
  power_wait_a: assert property (@(posedge clk) disable iff (rst)
    state == SSM_ON && power_lost && !undervoltage_trip_select && !bus_low_s
    |=> !servo_active && !main_undervoltage_error)
    else $error("servo not off on power loss");
  ignore_det_a: assert property (@(posedge clk) disable iff (rst)
    det_ignore && state == SSM_ON && !bus_low_s
    |=> state != SSM_PWR_WAIT && !main_undervoltage_error)
    else $error("loss declared at ignore setting");
  bus_low_a: assert property (@(posedge clk) disable iff (rst)
    bus_low_s && !power_lost |=> main_undervoltage_error)
    else $error("bus low without error");
  ot_hold_a: assert property (@(posedge clk) disable iff (rst)
    ot_active |=> deviation_hold)
    else $error("deviation not held in over-travel");
  ot_sel_a: assert property (@(posedge clk) disable iff (rst)
    ot_loaded |=> $stable(ot_sel))
    else $error("over-travel selection changed live");
endmodule : ssm_monitor
`default_nettype wire

// ==== hw/ssm_sync.sv ====
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes an asynchronous level input and one clock with sync reset.
*/
`default_nettype none
module ssm_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'h0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule : ssm_sync
`default_nettype wire

// ==== include/ssm_cfg.svh ====
/*
  Constants of the servo sequence monitor: reset values, hysteresis,
  special settings and timing. Assumes a 20 MHz control clock.
*/
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH

`define SSM_THR_W 15
`define SSM_THR_MIN 15'h000a
`define SSM_THR_MAX 15'h4e20
`define SSM_ZERO_THR_RST 15'h0032
`define SSM_AT_THR_RST 15'h0032
`define SSM_HYST_RPM 17'h0000a
`define SSM_UV_SEL_RST 1'h1
`define SSM_OT_SEL_RST 2'h0
`define SSM_DET_W 11
`define SSM_DET_IGNORE 11'h3e8
`define SSM_CLK_NS 50
`define SSM_MS_NS 1000000
`define SSM_CYC_PER_MS (`SSM_MS_NS / `SSM_CLK_NS)

`endif

// ==== include/ssm_pkg.sv ====
/*
  Types of the servo sequence monitor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ssm_pkg;
  // Gray order: off, on, waiting for power, tripped
  typedef enum logic [1:0] {
    SSM_OFF = 2'h0,
    SSM_ON = 2'h1,
    SSM_PWR_WAIT = 2'h3,
    SSM_TRIP = 2'h2
  } ssm_state_t;

  typedef enum logic [1:0] {
    SSM_OT_DB = 2'h0,
    SSM_OT_TQ0 = 2'h1,
    SSM_OT_ESTOP = 2'h2
  } ssm_ot_sel_t;
endpackage : ssm_pkg
`default_nettype wire

// ==== tb/ssm_host_model.sv ====
/*
  Host controller model driving the monitor's servo-on and alarm clear pins.
  Assumes the monitor's clock and its synchronous reset.
*/
`default_nettype none
module ssm_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic servo_request,
  input wire logic auto_clear,
  input wire logic main_undervoltage_error,
  output logic servo_on_pin,
  output logic alarm_clear_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clear held as a level; a short pulse could die in the pin filter
  always_ff @(posedge clk) begin
    if (rst) begin
      servo_on_pin <= 1'b0;
      alarm_clear_pin <= 1'b0;
    end else begin
      servo_on_pin <= servo_request;
      alarm_clear_pin <= auto_clear && main_undervoltage_error;
    end
  end
endmodule : ssm_host_model
`default_nettype wire

// ==== tb/tb_servo_sequence_monitor.sv ====
/*
  Bench of the servo sequence monitor: speed flags against a reference
  every cycle, then power loss and over-travel cases.
  Assumes ssm_monitor, ssm_host_model and ssm_pkg.
*/
`default_nettype none
module tb_servo_sequence_monitor;
  import ssm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic signed [15:0] spd = '0;
  logic signed [15:0] cmd = '0;
  logic signed [15:0] tqi = 16'sh0100;
  logic [14:0] zthr = 15'h0032;
  logic [14:0] athr = 15'h0032;
  logic uv_sel = 1'b1;
  ssm_ot_sel_t ot_sel = SSM_OT_DB;
  logic [10:0] det = 11'h002;
  logic [8:0] est = 9'h064;
  logic [8:0] ntl = 9'h1f4;
  logic srv_req = 1'b0;
  logic auto_clr = 1'b0;
  logic pwr_ok = 1'b1;
  logic bus_low = 1'b0;
  logic cw = 1'b0;
  logic ccw = 1'b0;
  logic srv_pin, clr_pin, zso, alt, smo, aso, err, act, db, hold;
  logic signed [15:0] tqo;
  logic [8:0] lim;
  logic e_zero, e_match, e_at;
  logic spd_chk = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int corner[12] = '{0, 49, 50, 55, 59, 60, -45, -50, -61, 40, 51, 0};
  int v;

  always #25 clk = ~clk;

  ssm_host_model host (.clk(clk), .rst(rst), .servo_request(srv_req),
    .auto_clear(auto_clr), .main_undervoltage_error(err),
    .servo_on_pin(srv_pin), .alarm_clear_pin(clr_pin));

  ssm_monitor #(.CYC_PER_MS(CPM)) dut (.clk(clk), .rst(rst),
    .motor_speed(spd), .speed_cmd(cmd), .torque_cmd_in(tqi),
    .zero_speed_threshold(zthr), .at_speed_threshold(athr),
    .undervoltage_trip_select(uv_sel), .overtravel_sequence_select(ot_sel),
    .power_off_detect_time(det), .estop_torque_setting(est),
    .normal_torque_limit(ntl), .servo_on_pin(srv_pin),
    .alarm_clear_pin(clr_pin), .main_power_ok_pin(pwr_ok),
    .bus_voltage_low_pin(bus_low), .cw_travel_inhibit(cw),
    .ccw_travel_inhibit(ccw), .zero_speed_out(zso), .alt_zero_speed_pin(alt),
    .speed_match_out(smo), .at_speed_out(aso), .main_undervoltage_error(err),
    .servo_active(act), .dynamic_brake(db), .deviation_hold(hold),
    .torque_cmd_out(tqo), .torque_limit_out(lim));

  function automatic int mag(input int x);
    return (x < 0) ? -x : x;
  endfunction : mag

  // Sets below thr, clears at thr+10 and up, keeps in the band
  function automatic logic band_lo(input logic p, input int x, input int t);
    return (x < t) ? 1'b1 : ((x >= t + 10) ? 1'b0 : p);
  endfunction : band_lo

  function automatic logic band_hi(input logic p, input int x, input int t);
    return (x > t) ? 1'b1 : ((x + 10 <= t) ? 1'b0 : p);
  endfunction : band_hi

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic do_reset();
    rst <= 1'b1;
    step(12);
    rst <= 1'b0;
    step(2);
  endtask : do_reset

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rst) begin
      e_zero <= 1'b1;
      e_match <= 1'b1;
      e_at <= 1'b0;
    end else begin
      e_zero <= band_lo(e_zero, mag(int'(spd)), int'(zthr));
      e_match <= band_lo(e_match, mag(int'(cmd) - int'(spd)), int'(zthr));
      e_at <= band_hi(e_at, mag(int'(spd)), int'(athr));
    end
  end

  // Ceiling well above the roughly 1000 cycles the run needs
  always @(posedge clk) begin
    if (cycles == 8000) begin
      mismatches++;
      final_report();
    end
  end

  always @(negedge clk) begin
    if (spd_chk) begin
      chk_bit(zso, e_zero);
      chk_bit(alt, e_zero);
      chk_bit(smo, e_match);
      chk_bit(aso, e_at);
    end
  end

  initial begin
    void'($urandom(32'hece6));
    step(11);
    @(negedge clk);
    chk_word({act, err, db, hold, tqo[11:0]}, 16'h0000);
    chk_word({7'h00, lim}, 16'h0000);
    step(1);
    rst <= 1'b0;
    spd_chk = 1'b1;
    foreach (corner[i]) begin
      spd <= 16'(corner[i]);
      step(2);
    end
    for (int i = 0; i < 300; i++) begin
      if (i % 20 == 0) begin
        zthr <= 15'(20 + $urandom_range(180));
        athr <= 15'(20 + $urandom_range(180));
      end
      v = int'(zthr) + int'($urandom_range(40)) - 20;
      if ($urandom_range(1) == 1) v = -v;
      spd <= 16'(v);
      cmd <= 16'(v + int'($urandom_range(120)) - 60);
      step(2);
    end
    zthr <= 15'h0032;
    spd <= '0;
    cmd <= '0;
    srv_req <= 1'b1;
    auto_clr <= 1'b1;
    step(12);
    pwr_ok <= 1'b0;
    step(5);
    @(negedge clk);
    chk_bit(err, 1'b0);
    step(25);
    @(negedge clk);
    chk_word({act, err}, 16'h0001);
    step(1);
    pwr_ok <= 1'b1;
    srv_req <= 1'b0;
    step(15);
    srv_req <= 1'b1;
    uv_sel <= 1'b0;
    step(12);
    pwr_ok <= 1'b0;
    step(30);
    @(negedge clk);
    chk_word({act, err}, 16'h0000);
    step(1);
    pwr_ok <= 1'b1;
    step(15);
    @(negedge clk);
    chk_bit(act, 1'b1);
    step(1);
    det <= 11'h3e8;
    uv_sel <= 1'b1;
    pwr_ok <= 1'b0;
    step(60);
    @(negedge clk);
    chk_word({act, err}, 16'h0002);
    step(1);
    bus_low <= 1'b1;
    step(10);
    @(negedge clk);
    chk_bit(err, 1'b1);
    step(1);
    bus_low <= 1'b0;
    pwr_ok <= 1'b1;
    det <= 11'h002;
    for (int s = 0; s < 3; s++) begin
      ot_sel <= ssm_ot_sel_t'(s);
      do_reset();
      ot_sel <= ssm_ot_sel_t'((s + 1) % 3);
      step(12);
      spd <= 16'sh03e8;
      tqi <= 16'sh0100;
      cw <= 1'b1;
      step(8);
      @(negedge clk);
      chk_word({db, hold}, {14'h0000, s == 0, 1'b1});
      chk_word(tqo, (s == 2) ? 16'h0100 : 16'h0000);
      chk_word({7'h00, lim}, {7'h00, (s == 2) ? est : ntl});
      step(1);
      spd <= '0;
      step(4);
      @(negedge clk);
      chk_word(tqo, 16'h0000);
      step(1);
      tqi <= -16'sh0100;
      step(3);
      @(negedge clk);
      chk_word(tqo, 16'hff00);
      step(1);
      cw <= 1'b0;
      ccw <= 1'b1;
      step(8);
      @(negedge clk);
      chk_word({hold, tqo[14:0]}, 16'h8000);
      step(1);
      ccw <= 1'b0;
    end
    final_report();
  end
endmodule : tb_servo_sequence_monitor
`default_nettype wire
